//--- sysmgt_defs.svh
// constants shared by both ends of the system management virtual wire link
// assumes it is included by bare name before any code that uses the macros
//
// What this block does
// - decode core state commands by upper bits
// - core performance-state commands travel downstream only
// - software-writable core and state counts exist
// - software programs counts before enabling tracking
// - controller sends input-wire changes upstream, posted
// - host reflects input-wire messages down every chain
// - one means asserted, zero means deasserted
// - wire message precedes response to causing request
// - wire message carries the response's unit tag
// - response after wire message clears pass flag
// - host stalls until wire message takes effect
// - host broadcasts float error and mode ack
// - mode ack follows entry and exit of mode
// - all wires deasserted after reset, both sides
`ifndef SYSMGT_DEFS_SVH
`define SYSMGT_DEFS_SVH

`define SM_CMD_W 12
`define SM_CLASS_PSTATE 5'h03
`define SM_CLASS_EXT_PSTATE 5'h04
`define SM_CLASS_IDLE 5'h05
`define SM_RSVD_BASE 12'h0300

`define SM_WIRE_NUM_ERR_IGN 0
`define SM_WIRE_ADDR_MASK 1
`define SM_WIRE_STOP_CLK 2
`define SM_WIRE_FLOAT_ERR 3
`define SM_WIRE_MGMT_ACK 4
`define SM_WIRES_RESET 5'h00

`define SM_REG_CTRL 8'h00
`define SM_REG_CONFIG 8'h04
`define SM_REG_WIRES 8'h08
`define SM_REG_STATUS 8'h0C
`define SM_REG_TRACK 8'h10

`define SM_CFG_CORES_LSB 0
`define SM_CFG_STATES_LSB 8
`define SM_STAT_BAD_BIT 8
`define SM_TRK_P_LSB 8
`define SM_TRK_C_LSB 16
`define SM_COUNT_RESET 5'h10
`define SM_UNIT_TAG_RESET 5'h01

`endif

//--- sysmgt_pkg.sv
// types shared by both ends of the system management virtual wire link
// assumes sysmgt_defs.svh is on the include path
`default_nettype none
`include "sysmgt_defs.svh"
package sysmgt_pkg;
   typedef enum logic [1:0] {DN_IDLE, DN_MGMT_CMD, DN_WIRES, DN_NP_REQ} dn_kind_t;
   typedef enum logic [1:0] {UP_IDLE, UP_WIRE_MSG, UP_RESPONSE} up_kind_t;
   typedef enum logic [2:0] {CMD_OTHER, CMD_PSTATE, CMD_EXT_PSTATE, CMD_IDLE_STATE,
      CMD_RESERVED} cmd_class_t;

   function automatic cmd_class_t classify(input logic [`SM_CMD_W-1:0] code);
      cmd_class_t c;
      c = CMD_OTHER;
      if (code >= `SM_RSVD_BASE)
         c = CMD_RESERVED;
      else if (code[11:7] == `SM_CLASS_PSTATE)
         c = CMD_PSTATE;
      else if (code[11:7] == `SM_CLASS_EXT_PSTATE)
         c = CMD_EXT_PSTATE;
      else if (code[11:7] == `SM_CLASS_IDLE)
         c = CMD_IDLE_STATE;
      return c;
   endfunction
endpackage
`default_nettype wire

//--- sysmgt_link_if.sv
// link between host and system management controller, one message per cycle each way
// assumes the bench drives linkClk and a synchronous active-high linkRst
`default_nettype none
`include "sysmgt_defs.svh"
interface sysmgt_link_if (
   input wire logic linkClk,
   input wire logic linkRst
);
   sysmgt_pkg::dn_kind_t dnKind;
   logic [`SM_CMD_W-1:0] dnCmd;
   logic [4:0] dnWires;
   sysmgt_pkg::up_kind_t upKind;
   logic [2:0] upWires;
   logic [4:0] upTag;
   logic upPassPw;

   modport host (input linkClk, input linkRst, output dnKind, output dnCmd,
      output dnWires, input upKind, input upWires, input upTag, input upPassPw);
   modport device (input linkClk, input linkRst, input dnKind, input dnCmd,
      input dnWires, output upKind, output upWires, output upTag, output upPassPw);
endinterface
`default_nettype wire

//--- sysmgt_host_end.sv
// host end: sends commands, output wires, requests; applies and reflects input wires
// assumes user ports are synchronous to the link clock
`default_nettype none
`include "sysmgt_defs.svh"
module sysmgt_host_end (
   sysmgt_link_if.host link,
   input wire logic sendCmd,
   input wire logic [`SM_CMD_W-1:0] cmdCode,
   input wire logic npReq,
   input wire logic npAddrMask,
   input wire logic npStopClk,
   input wire logic floatErr,
   input wire logic smmActive,
   output logic cmdBusy,
   output logic cpuStall,
   output logic [2:0] procWires
);
   typedef struct packed {
      logic cmdPend;
      logic [`SM_CMD_W-1:0] cmdCode;
      logic npPend;
      logic [1:0] npWires;
      logic stall;
      logic [2:0] procWires;
      logic reflectPend;
      logic [1:0] sentOut;
      sysmgt_pkg::dn_kind_t dnKind;
      logic [`SM_CMD_W-1:0] dnCmd;
      logic [4:0] dnWires;
   } host_state_t;

   host_state_t s_ff;
   host_state_t nxt_s;
   logic [1:0] outNow;

   assign outNow = {smmActive, floatErr};
   assign cmdBusy = s_ff.cmdPend;
   assign cpuStall = s_ff.stall;
   assign procWires = s_ff.procWires;
   assign link.dnKind = s_ff.dnKind;
   assign link.dnCmd = s_ff.dnCmd;
   assign link.dnWires = s_ff.dnWires;

   always_comb
   begin
      nxt_s = s_ff;
      nxt_s.dnKind = sysmgt_pkg::DN_IDLE;
      nxt_s.dnCmd = '0;
      nxt_s.dnWires = '0;
      if (sendCmd)
      begin
         nxt_s.cmdPend = 1'b1;
         nxt_s.cmdCode = cmdCode;
      end
      if (npReq && !s_ff.stall)
      begin
         nxt_s.npPend = 1'b1;
         nxt_s.npWires = {npStopClk, npAddrMask};
         nxt_s.stall = 1'b1;
      end
      // a wire message arrives ahead of its response, so effects land before release
      case (link.upKind)
         sysmgt_pkg::UP_WIRE_MSG:
         begin
            nxt_s.procWires = link.upWires;
            nxt_s.reflectPend = 1'b1;
         end
         sysmgt_pkg::UP_RESPONSE:
            nxt_s.stall = 1'b0;
         default:
            nxt_s.stall = nxt_s.stall;
      endcase
      if (s_ff.reflectPend || outNow != s_ff.sentOut)
      begin
         nxt_s.dnKind = sysmgt_pkg::DN_WIRES;
         nxt_s.dnWires = {outNow, s_ff.procWires};
         nxt_s.sentOut = outNow;
         nxt_s.reflectPend = (link.upKind == sysmgt_pkg::UP_WIRE_MSG);
      end
      else if (s_ff.npPend)
      begin
         nxt_s.dnKind = sysmgt_pkg::DN_NP_REQ;
         nxt_s.dnWires = {2'b00, s_ff.npWires, 1'b0};
         nxt_s.npPend = 1'b0;
      end
      else if (s_ff.cmdPend)
      begin
         nxt_s.dnKind = sysmgt_pkg::DN_MGMT_CMD;
         nxt_s.dnCmd = s_ff.cmdCode;
         nxt_s.cmdPend = sendCmd;
      end
   end

   always_ff @(posedge link.linkClk)
   begin
      if (link.linkRst)
         s_ff <= '0;
      else
         s_ff <= nxt_s;
   end
endmodule // sysmgt_host_end
`default_nettype wire

//--- sysmgt_device_end.sv
// device end: system management controller with per-core state tracker
// assumes the link clock comes from the interface and APB runs on clk;
// config crossing is quasi-static, so software changes the counts only while tracking is off
`default_nettype none
`include "sysmgt_defs.svh"
module sysmgt_device_end #(
   parameter logic [4:0] UNIT_TAG = `SM_UNIT_TAG_RESET
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   sysmgt_link_if.device link
);
   // cfg bus: [0] enable, [5:1] cores, [10:6] states, [13:11] wires, [17:14] core select
   // stat bus: [4:0] link wires, [8:5] selected p-state, [11:9] selected c-state
   typedef struct packed {
      logic ctrlEn;
      logic [4:0] coreCount;
      logic [4:0] stateCount;
      logic [2:0] swWires;
      logic [3:0] coreSel;
      logic [11:0] stMeta;
      logic [11:0] stSync;
      logic [11:0] stHold;
      logic badMeta;
      logic badSync;
      logic badPrev;
      logic badSticky;
      logic [31:0] prdata;
      logic pslverr;
   } bus_state_t;

   typedef struct packed {
      logic [17:0] cfgMeta;
      logic [17:0] cfgSync;
      logic [2:0] prevSw;
      logic [4:0] wires;
      logic respPending;
      sysmgt_pkg::up_kind_t upKind;
      logic [2:0] upWires;
      logic upPassPw;
      logic [15:0][3:0] pstate;
      logic [15:0][2:0] cstate;
      logic badToggle;
      logic [11:0] statBus;
   } link_state_t;

   bus_state_t b_ff;
   bus_state_t nxt_b;
   link_state_t l_ff;
   link_state_t nxt_l;
   logic [17:0] cfgBus;
   logic [31:0] rdValue;
   logic rdHit;

   assign cfgBus = {b_ff.coreSel, b_ff.swWires, b_ff.stateCount, b_ff.coreCount, b_ff.ctrlEn};
   assign pready = 1'b1;
   assign prdata = b_ff.prdata;
   assign pslverr = b_ff.pslverr;
   assign link.upKind = l_ff.upKind;
   assign link.upWires = l_ff.upWires;
   assign link.upTag = UNIT_TAG;
   assign link.upPassPw = l_ff.upPassPw;

   // read mux, sampled in the setup cycle so data stands for the access cycle
   always_comb
   begin
      rdHit = 1'b1;
      rdValue = 32'h0000_0000;
      case (paddr)
         `SM_REG_CTRL:
            rdValue[0] = b_ff.ctrlEn;
         `SM_REG_CONFIG:
         begin
            rdValue[`SM_CFG_CORES_LSB +: 5] = b_ff.coreCount;
            rdValue[`SM_CFG_STATES_LSB +: 5] = b_ff.stateCount;
         end
         `SM_REG_WIRES:
            rdValue[2:0] = b_ff.swWires;
         `SM_REG_STATUS:
         begin
            rdValue[4:0] = b_ff.stHold[4:0];
            rdValue[`SM_STAT_BAD_BIT] = b_ff.badSticky;
         end
         `SM_REG_TRACK:
         begin
            rdValue[3:0] = b_ff.coreSel;
            rdValue[`SM_TRK_P_LSB +: 4] = b_ff.stHold[8:5];
            rdValue[`SM_TRK_C_LSB +: 3] = b_ff.stHold[11:9];
         end
         default:
            rdHit = 1'b0;
      endcase
   end

   always_comb
   begin
      nxt_b = b_ff;
      nxt_b.stMeta = l_ff.statBus;
      nxt_b.stSync = b_ff.stMeta;
      // the status word crosses bit by bit, so only a value seen twice in a row is shown
      if (b_ff.stMeta == b_ff.stSync)
         nxt_b.stHold = b_ff.stSync;
      nxt_b.badMeta = l_ff.badToggle;
      nxt_b.badSync = b_ff.badMeta;
      nxt_b.badPrev = b_ff.badSync;
      if (psel && !penable)
      begin
         nxt_b.prdata = pwrite ? 32'h0000_0000 : rdValue;
         nxt_b.pslverr = !rdHit;
      end
      if (psel && penable && pwrite)
      begin
         case (paddr)
            `SM_REG_CTRL:
               nxt_b.ctrlEn = pwdata[0];
            `SM_REG_CONFIG:
            begin
               nxt_b.coreCount = pwdata[`SM_CFG_CORES_LSB +: 5];
               nxt_b.stateCount = pwdata[`SM_CFG_STATES_LSB +: 5];
            end
            `SM_REG_WIRES:
               nxt_b.swWires = pwdata[2:0];
            `SM_REG_STATUS:
               if (pwdata[`SM_STAT_BAD_BIT])
                  nxt_b.badSticky = 1'b0;
            `SM_REG_TRACK:
               nxt_b.coreSel = pwdata[3:0];
            default:
               nxt_b.coreSel = b_ff.coreSel;
         endcase
      end
      // set after clear so a new bad command is never lost
      if (b_ff.badSync != b_ff.badPrev)
         nxt_b.badSticky = 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         b_ff <= '0;
         b_ff.coreCount <= `SM_COUNT_RESET;
         b_ff.stateCount <= `SM_COUNT_RESET;
      end
      else
         b_ff <= nxt_b;
   end

   // link side
   always_comb
   begin
      logic en;
      logic [4:0] cores;
      logic [4:0] states;
      logic [2:0] sw;
      logic [2:0] chg;
      logic [2:0] newIn;
      logic [3:0] core;
      logic [2:0] idx;
      en = l_ff.cfgSync[0];
      cores = l_ff.cfgSync[5:1];
      states = l_ff.cfgSync[10:6];
      sw = l_ff.cfgSync[13:11];
      chg = sw ^ l_ff.prevSw;
      newIn = l_ff.wires[2:0];
      core = link.dnCmd[6:3];
      idx = link.dnCmd[2:0];
      nxt_l = l_ff;
      nxt_l.cfgMeta = cfgBus;
      nxt_l.cfgSync = l_ff.cfgMeta;
      nxt_l.upKind = sysmgt_pkg::UP_IDLE;
      nxt_l.upWires = '0;
      nxt_l.upPassPw = 1'b0;
      if (l_ff.respPending)
      begin
         nxt_l.upKind = sysmgt_pkg::UP_RESPONSE;
         nxt_l.upPassPw = 1'b0;
         nxt_l.respPending = 1'b0;
      end
      else if (link.dnKind == sysmgt_pkg::DN_NP_REQ)
      begin
         newIn[`SM_WIRE_ADDR_MASK] = link.dnWires[`SM_WIRE_ADDR_MASK];
         newIn[`SM_WIRE_STOP_CLK] = link.dnWires[`SM_WIRE_STOP_CLK];
         if (newIn != l_ff.wires[2:0])
         begin
            nxt_l.upKind = sysmgt_pkg::UP_WIRE_MSG;
            nxt_l.upWires = newIn;
            nxt_l.respPending = 1'b1;
         end
         else
         begin
            nxt_l.upKind = sysmgt_pkg::UP_RESPONSE;
            nxt_l.upPassPw = 1'b1;
         end
      end
      else if (chg != 3'b000)
      begin
         // a software change waits out a request cycle; prevSw holds it until sent
         newIn = (l_ff.wires[2:0] & ~chg) | (sw & chg);
         nxt_l.prevSw = sw;
         if (newIn != l_ff.wires[2:0])
         begin
            nxt_l.upKind = sysmgt_pkg::UP_WIRE_MSG;
            nxt_l.upWires = newIn;
         end
      end
      nxt_l.wires[2:0] = newIn;
      // core state commands are only ever taken from the downstream channel
      if (link.dnKind == sysmgt_pkg::DN_MGMT_CMD)
      begin
         case (sysmgt_pkg::classify(link.dnCmd))
            sysmgt_pkg::CMD_PSTATE:
               if (en && {1'b0, core} < cores && {2'b00, idx} < states)
                  nxt_l.pstate[core] = {1'b0, idx};
            sysmgt_pkg::CMD_EXT_PSTATE:
               if (en && {1'b0, core} < cores && {1'b0, 1'b1, idx} < states)
                  nxt_l.pstate[core] = {1'b1, idx};
            sysmgt_pkg::CMD_IDLE_STATE:
               if (en && {1'b0, core} < cores)
                  nxt_l.cstate[core] = idx;
            sysmgt_pkg::CMD_RESERVED:
               nxt_l.badToggle = !l_ff.badToggle;
            default:
               nxt_l.badToggle = l_ff.badToggle;
         endcase
      end
      if (link.dnKind == sysmgt_pkg::DN_WIRES)
      begin
         nxt_l.wires[`SM_WIRE_FLOAT_ERR] = link.dnWires[`SM_WIRE_FLOAT_ERR];
         nxt_l.wires[`SM_WIRE_MGMT_ACK] = link.dnWires[`SM_WIRE_MGMT_ACK];
      end
      nxt_l.statBus = {l_ff.cstate[l_ff.cfgSync[17:14]], l_ff.pstate[l_ff.cfgSync[17:14]],
         l_ff.wires};
   end

   always_ff @(posedge link.linkClk)
   begin
      if (link.linkRst)
      begin
         l_ff <= '0;
         l_ff.wires <= `SM_WIRES_RESET;
      end
      else
         l_ff <= nxt_l;
   end
endmodule // sysmgt_device_end
`default_nettype wire

//--- sysmgt_link_sva.sv
// checker for the virtual wire link, watching the interface signals
// assumes the bench instantiates it beside the interface joining both ends
`default_nettype none
`include "sysmgt_defs.svh"
module sysmgt_link_sva #(
   parameter logic [4:0] UNIT_TAG = `SM_UNIT_TAG_RESET
) (
   input wire logic linkClk,
   input wire logic linkRst,
   input wire sysmgt_pkg::dn_kind_t dnKind,
   input wire logic [`SM_CMD_W-1:0] dnCmd,
   input wire logic [4:0] dnWires,
   input wire sysmgt_pkg::up_kind_t upKind,
   input wire logic [2:0] upWires,
   input wire logic [4:0] upTag,
   input wire logic upPassPw
);
   timeunit 1ns;
   timeprecision 1ps;
   // last input-wire state carried upstream, so a request can be judged as a change
   logic [2:0] seenWires;
   default clocking @(posedge linkClk); endclocking
   default disable iff (linkRst);
   always_ff @(posedge linkClk)
   begin
      if (linkRst)
         seenWires <= 3'h0;
      else if (upKind == sysmgt_pkg::UP_WIRE_MSG)
         seenWires <= upWires;
   end
   property p_np_change;
      dnKind == sysmgt_pkg::DN_NP_REQ && dnWires[2:1] != seenWires[2:1] |=>
         upKind == sysmgt_pkg::UP_WIRE_MSG && upWires[2:1] == $past(dnWires[2:1]);
   endproperty
   a_np_change: assert property (p_np_change) else $error("wire message missing");
   property p_np_same;
      dnKind == sysmgt_pkg::DN_NP_REQ && dnWires[2:1] == seenWires[2:1] |=>
         upKind == sysmgt_pkg::UP_RESPONSE && upPassPw;
   endproperty
   a_np_same: assert property (p_np_same) else $error("plain response wrong");
   property p_msg_resp;
      upKind == sysmgt_pkg::UP_WIRE_MSG && $past(dnKind) == sysmgt_pkg::DN_NP_REQ |=>
         upKind == sysmgt_pkg::UP_RESPONSE && !upPassPw;
   endproperty
   a_msg_resp: assert property (p_msg_resp) else $error("response after message");
   property p_resp_cause;
      upKind == sysmgt_pkg::UP_RESPONSE |-> $past(dnKind) == sysmgt_pkg::DN_NP_REQ ||
         ($past(dnKind, 2) == sysmgt_pkg::DN_NP_REQ && $past(upKind) == sysmgt_pkg::UP_WIRE_MSG);
   endproperty
   a_resp_cause: assert property (p_resp_cause) else $error("response out of order");
   property p_tag;
      upKind != sysmgt_pkg::UP_IDLE |-> upTag == UNIT_TAG;
   endproperty
   a_tag: assert property (p_tag) else $error("unit tag differs");
   property p_up_zero;
      upKind != sysmgt_pkg::UP_WIRE_MSG |-> upWires == 3'h0;
   endproperty
   a_up_zero: assert property (p_up_zero) else $error("stray wire bits");
   property p_cmd_zero;
      dnKind != sysmgt_pkg::DN_MGMT_CMD |-> dnCmd == 12'h000;
   endproperty
   a_cmd_zero: assert property (p_cmd_zero) else $error("stray command code");
   property p_reflect;
      upKind == sysmgt_pkg::UP_WIRE_MSG |->
         ##[1:4] (dnKind == sysmgt_pkg::DN_WIRES && dnWires[2:0] == seenWires);
   endproperty
   a_reflect: assert property (p_reflect) else $error("wire change not reflected");
   property p_reset;
      $fell(linkRst) |-> dnWires == 5'h00 && dnKind == sysmgt_pkg::DN_IDLE &&
         upKind == sysmgt_pkg::UP_IDLE;
   endproperty
   a_reset: assert property (p_reset) else $error("link not idle after reset");
endmodule // sysmgt_link_sva
`default_nettype wire

//--- sysmgt_virtual_wire_codec_bench.sv
// bench: host and device ends joined by the link, registers over APB on clk
// assumes the design files, package and header are compiled first
`default_nettype none
`include "sysmgt_defs.svh"
module sysmgt_virtual_wire_codec_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, linkClk = 0, rst = 1, linkRst = 1;
   logic psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic sendCmd = 0, npReq = 0, npAddrMask = 0, npStopClk = 0, floatErr = 0, smmActive = 0;
   logic [11:0] cmdCode = 12'h000;
   logic cmdBusy, cpuStall;
   logic [2:0] procWires;
   logic [11:0] codes [5] = '{12'h195, 12'h213, 12'h296, 12'h1A1, 12'h19F};
   int badCount = 0, numChecks = 0;
   always #20 clk = ~clk;
   // odd multiples of 3 ns never meet the main clock's rising edges
   always #3 linkClk = ~linkClk;
   sysmgt_link_if linkBus (.linkClk(linkClk), .linkRst(linkRst));
   sysmgt_host_end sysmgt_host_end_inst (.link(linkBus), .sendCmd(sendCmd),
      .cmdCode(cmdCode), .npReq(npReq), .npAddrMask(npAddrMask), .npStopClk(npStopClk),
      .floatErr(floatErr), .smmActive(smmActive), .cmdBusy(cmdBusy), .cpuStall(cpuStall),
      .procWires(procWires));
   sysmgt_device_end #(.UNIT_TAG(5'h01)) sysmgt_device_end_inst (.clk(clk), .rst(rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(linkBus));
   sysmgt_link_sva #(.UNIT_TAG(5'h01)) sysmgt_link_sva_inst (.linkClk(linkClk),
      .linkRst(linkRst), .dnKind(linkBus.dnKind), .dnCmd(linkBus.dnCmd),
      .dnWires(linkBus.dnWires), .upKind(linkBus.upKind), .upWires(linkBus.upWires),
      .upTag(linkBus.upTag), .upPassPw(linkBus.upPassPw));
   task automatic endOfTest;
      $display("checks %0d mismatches %0d", numChecks, badCount);
      if (badCount == 0 && numChecks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      numChecks++;
      if (seen !== exp)
      begin
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
         badCount++;
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
      begin
         badCount++;
         endOfTest();
      end
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      check("register", rd, exp);
   endtask
   task automatic settle;
      repeat (12) @(posedge clk);
   endtask
   task automatic hostWait;
      int n;
      n = 0;
      do
      begin
         @(posedge linkClk);
         n++;
      end
      while ((cmdBusy !== 1'b0 || cpuStall !== 1'b0) && n < 100);
      if (n >= 100)
      begin
         badCount++;
         endOfTest();
      end
      settle();
   endtask
   task automatic sendCode(input logic [11:0] c);
      @(posedge linkClk);
      sendCmd <= 1'b1;
      cmdCode <= c;
      @(posedge linkClk);
      sendCmd <= 1'b0;
      hostWait();
   endtask
   task automatic npOp(input logic am, input logic sc, input logic [2:0] exp);
      @(posedge linkClk);
      npReq <= 1'b1;
      npAddrMask <= am;
      npStopClk <= sc;
      @(posedge linkClk);
      npReq <= 1'b0;
      #1 check("cpuStall", 32'(cpuStall), 32'h0000_0001);
      hostWait();
      check("procWires", 32'(procWires), 32'(exp));
   endtask
   task automatic track(input logic [3:0] core, input logic [3:0] p, input logic [2:0] c);
      apb(1'b1, `SM_REG_TRACK, 32'(core));
      // the selected core's state must cross into the bus domain before it is read
      settle();
      apb(1'b0, `SM_REG_TRACK, 32'h0000_0000);
      check("track", rd & 32'h0007_0F0F, {13'h0000, c, 4'h0, p, 4'h0, core});
   endtask
   task automatic doReset;
      rst <= 1'b1;
      linkRst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge linkClk);
      linkRst <= 1'b0;
      settle();
      check("procWires", 32'(procWires), 32'h0000_0000);
      rdChk(`SM_REG_CONFIG, 32'h0000_1010);
      rdChk(`SM_REG_STATUS, 32'h0000_0000);
   endtask
   initial
   begin
      doReset();
      apb(1'b1, 8'h40, 32'h0000_0001);
      check("pslverr", 32'(pslverr), 32'h0000_0001);
      apb(1'b1, `SM_REG_CONFIG, 32'h0000_1004);
      rdChk(`SM_REG_CONFIG, 32'h0000_1004);
      apb(1'b1, `SM_REG_CTRL, 32'h0000_0001);
      settle();
      foreach (codes[i])
         sendCode(codes[i]);
      // a code outside the core classes names core 2 too and must change nothing
      sendCode(12'h015);
      track(4'h2, 4'hB, 3'h6);
      track(4'h3, 4'h7, 3'h0);
      track(4'h4, 4'h0, 3'h0);
      // tracking off: a later command must leave the tracker alone
      apb(1'b1, `SM_REG_CTRL, 32'h0000_0000);
      settle();
      sendCode(12'h190);
      track(4'h2, 4'hB, 3'h6);
      sendCode(12'h300);
      rdChk(`SM_REG_STATUS, 32'h0000_0100);
      apb(1'b1, `SM_REG_STATUS, 32'h0000_0100);
      sendCode(12'hFFF);
      rdChk(`SM_REG_STATUS, 32'h0000_0100);
      apb(1'b1, `SM_REG_STATUS, 32'h0000_0100);
      rdChk(`SM_REG_STATUS, 32'h0000_0000);
      @(posedge linkClk);
      floatErr <= 1'b1;
      smmActive <= 1'b1;
      settle();
      rdChk(`SM_REG_STATUS, 32'h0000_0018);
      apb(1'b1, `SM_REG_WIRES, 32'h0000_0005);
      settle();
      check("procWires", 32'(procWires), 32'h0000_0005);
      rdChk(`SM_REG_STATUS, 32'h0000_001D);
      apb(1'b1, `SM_REG_WIRES, 32'h0000_0000);
      settle();
      check("procWires", 32'(procWires), 32'h0000_0000);
      npOp(1'b0, 1'b1, 3'h4);
      npOp(1'b1, 1'b1, 3'h6);
      npOp(1'b1, 1'b1, 3'h6);
      rdChk(`SM_REG_STATUS, 32'h0000_001E);
      npOp(1'b0, 1'b0, 3'h0);
      @(posedge linkClk);
      floatErr <= 1'b0;
      smmActive <= 1'b0;
      settle();
      rdChk(`SM_REG_STATUS, 32'h0000_0000);
      // wires asserted going into reset, so the reset checks see a real change
      apb(1'b1, `SM_REG_WIRES, 32'h0000_0007);
      settle();
      check("procWires", 32'(procWires), 32'h0000_0007);
      doReset();
      endOfTest();
   end
endmodule // sysmgt_virtual_wire_codec_bench
`default_nettype wire
